//--- verilog/rsf_top.sv
// Event status flags, time holding and calibration output over AHB-Lite
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module rsf_top (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [rsf_pkg::TIME_W-1:0] cur_time,
  input  wire logic                   supply_low,
  input  wire logic                   alarm_irq_n_in,
  output logic                        int_out
);
  import rsf_pkg::*;

  typedef struct packed {
    logic              dp_act;
    logic              dp_wr;
    logic [7:0]        dp_addr;
    logic [31:0]       rdata;
    logic              alarm_hit_flag;
    logic              supply_loss_flag;
    logic              cal_en;
    logic              read_hold;
    logic [TIME_W-1:0] alarm_val;
    logic [FIELDS-1:0] ignore;
    logic [TIME_W-1:0] hold_time;
    logic              hit_d;
    logic [15:0]       cal_cnt;
    logic              cal_wave;
    logic              int_q;
    logic              rdy_q;
    logic              resp_q;
  } rsf_state_t;

  rsf_state_t s_r;
  rsf_state_t s_nxt;

  rsf_cmp_if cmp_bus ();
  assign cmp_bus.now_time   = cur_time;
  assign cmp_bus.alarm_time = s_r.alarm_val;
  assign cmp_bus.ignore     = s_r.ignore;

  rsf_alarm_cmp u_cmp (
    .c (cmp_bus.cmp)
  );

  function automatic logic [7:0] status_byte(input rsf_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_ALARM]  = s.alarm_hit_flag;
    b[BIT_SUPPLY] = s.supply_loss_flag;
    b[BIT_CAL]    = s.cal_en;
    b[BIT_READ]   = s.read_hold;
    return b;
  endfunction

  logic addr_ph;
  assign addr_ph = hsel && hready && htrans[1];

  always_comb begin
    s_nxt = s_r;
    s_nxt.dp_act  = addr_ph;
    s_nxt.dp_wr   = addr_ph && hwrite;
    s_nxt.dp_addr = addr_ph ? haddr[7:0] : s_r.dp_addr;
    s_nxt.hit_d   = cmp_bus.hit;
    // Zero wait states and OKAY only, kept in flops for clean outputs
    s_nxt.rdy_q   = 1'b1;
    s_nxt.resp_q  = 1'b0;

    // Read data prepared in address phase, presented next cycle
    s_nxt.rdata = 32'h00000000;
    if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        OFF_STATUS: s_nxt.rdata = {24'h000000, status_byte(s_r)};
        OFF_ALARM:  s_nxt.rdata = s_r.alarm_val;
        OFF_ENABLE: s_nxt.rdata = {28'h0000000, s_r.ignore};
        OFF_TIME:   s_nxt.rdata = cur_time;
        OFF_HOLD:   s_nxt.rdata = s_r.hold_time;
        default:    s_nxt.rdata = 32'h00000000;
      endcase
    end

    // Clear-on-read happens in the address phase; a same-cycle set wins
    if (addr_ph && !hwrite && haddr[7:0] == OFF_STATUS) begin
      s_nxt.alarm_hit_flag   = 1'b0;
      s_nxt.supply_loss_flag = 1'b0;
    end
    // Rising edge of match avoids retrigger while time stays equal
    if (cmp_bus.hit && !s_r.hit_d)
      s_nxt.alarm_hit_flag = 1'b1;
    if (supply_low)
      s_nxt.supply_loss_flag = 1'b1;

    if (s_r.dp_act && s_r.dp_wr) begin
      unique case (s_r.dp_addr)
        OFF_STATUS: begin
          s_nxt.cal_en    = hwdata[BIT_CAL];
          s_nxt.read_hold = hwdata[BIT_READ];
        end
        OFF_ALARM:  s_nxt.alarm_val = hwdata[TIME_W-1:0];
        OFF_ENABLE: s_nxt.ignore    = hwdata[FIELDS-1:0];
        default: ;
      endcase
    end

    // Holding copy tracks time only while not frozen
    if (!s_r.read_hold)
      s_nxt.hold_time = cur_time;

    if (s_r.cal_en) begin
      if (s_r.cal_cnt == 16'(CAL_HALF - 1)) begin
        s_nxt.cal_cnt  = 16'h0000;
        s_nxt.cal_wave = !s_r.cal_wave;
      end else begin
        s_nxt.cal_cnt = s_r.cal_cnt + 16'h0001;
      end
    end else begin
      s_nxt.cal_cnt  = 16'h0000;
      s_nxt.cal_wave = 1'b0;
    end
    s_nxt.int_q = s_r.cal_en ? s_r.cal_wave : alarm_irq_n_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.alarm_val <= 32'h00000000;
      s_r.int_q     <= 1'b1;
      s_r.rdy_q     <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign hrdata    = s_r.rdata;
  assign hreadyout = s_r.rdy_q;
  assign hresp     = s_r.resp_q;
  assign int_out   = s_r.int_q;
endmodule

//--- verilog/rsf_pkg.sv
// Package of constants for the event status flag block
package rsf_pkg;
  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_ALARM   = 8'h04;
  localparam logic [7:0] OFF_ENABLE  = 8'h08;
  localparam logic [7:0] OFF_TIME    = 8'h0c;
  localparam logic [7:0] OFF_HOLD    = 8'h10;
  localparam logic [7:0] OFF_CTRL    = 8'h14;
  // Status bit positions
  localparam int BIT_ALARM  = 6;
  localparam int BIT_SUPPLY = 5;
  localparam int BIT_CAL    = 2;
  localparam int BIT_READ   = 0;
  // Time word layout: sec, min, hour, date (bytes 0..3)
  localparam int FIELDS   = 4;
  localparam int FIELD_W  = 8;
  localparam int TIME_W   = FIELDS * FIELD_W;
  // Calibration output timing
  localparam int CLK_HZ   = 25_000_000;
  localparam int CAL_HZ   = 512;
  localparam int CAL_HALF = CLK_HZ / (2 * CAL_HZ);
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [31:0] ENABLE_RST = 32'h00000000;
endpackage

//--- verilog/rsf_cmp_if.sv
// Interface carrying alarm comparison operands and result
`timescale 1ns/1ps
interface rsf_cmp_if;
  import rsf_pkg::*;
  logic [TIME_W-1:0]  now_time;
  logic [TIME_W-1:0]  alarm_time;
  logic [FIELDS-1:0]  ignore;
  logic               hit;
  modport core (output now_time, output alarm_time, output ignore,
                input hit);
  modport cmp  (input now_time, input alarm_time, input ignore,
                output hit);
endinterface

//--- verilog/rsf_alarm_cmp.sv
// Per-field alarm comparator with match-enable masking
`timescale 1ns/1ps
module rsf_alarm_cmp (
  rsf_cmp_if.cmp c
);
  import rsf_pkg::*;
  logic [FIELDS-1:0] fld_ok;
  genvar g;
  generate
    for (g = 0; g < FIELDS; g++) begin : g_fld
      // Field with ignore bit set takes no part in the match
      assign fld_ok[g] = c.ignore[g] ||
        (c.now_time[g*FIELD_W +: FIELD_W] ==
         c.alarm_time[g*FIELD_W +: FIELD_W]);
    end
  endgenerate
  assign c.hit = &fld_ok;
endmodule

//--- dv/rsf_assertions.sv
// Bus-side and interrupt pin checks of the status flag block
`timescale 1ns/1ps
module rsf_assertions (
  input logic        hclk, hresetn, clk_en, hsel, hwrite, hready,
  input logic [1:0]  htrans,
  input logic [31:0] haddr, hwdata, hrdata, cur_time,
  input logic        supply_low, alarm_irq_n_in, int_out
);
  import rsf_pkg::*;
  logic go, rs, rh_rd, wp, cal, rh;
  assign go = hsel && hready && htrans[1] && clk_en;
  assign rs = go && !hwrite && haddr[7:0] == OFF_STATUS;
  assign rh_rd = go && !hwrite && haddr[7:0] == OFF_HOLD;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mirror of the writable bits, taken in the data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) {wp, cal, rh} <= 3'h0;
    else if (clk_en) begin
      wp <= go && hwrite && haddr[7:0] == OFF_STATUS;
      if (wp) {cal, rh} <= {hwdata[BIT_CAL], hwdata[BIT_READ]};
    end
  a_sup_set: assert property (supply_low ##1 rs |=> hrdata[5])
    else $error("supply flag missing");
  a_sup_clr: assert property (
    rs && !supply_low ##1 !supply_low ##1 rs |=> !hrdata[5])
    else $error("supply flag not cleared");
  a_alm_clr: assert property (
    rs && $stable(cur_time) ##1 $stable(cur_time) ##1 rs |=> !hrdata[6])
    else $error("alarm flag not cleared");
  a_st_bits: assert property (rs |=> hrdata[2] == cal && hrdata[0] == rh)
    else $error("status control bits wrong");
  a_hold_frz: assert property (
    rh && rh_rd ##2 rh_rd |=> hrdata == $past(hrdata, 2))
    else $error("frozen time moved");
  a_hold_run: assert property (
    rh_rd && !rh && !$past(rh) && $stable(cur_time)
    |=> hrdata == $past(cur_time))
    else $error("holding time not tracking");
  a_int_flw: assert property (
    $past(hresetn) && $past(clk_en) && !cal && !$past(cal)
    |-> int_out == $past(alarm_irq_n_in))
    else $error("interrupt pin not following");
  a_cal_hld: assert property (
    cal && $past(cal, 2) && $changed(int_out)
    |=> ($stable(int_out) || !cal)[*8])
    else $error("square wave too fast");
endmodule

//--- dv/rsf_host.sv
// Host bus master model issuing single word transfers
`timescale 1ns/1ps
module rsf_host (
  input  logic        hclk, hready,
  input  logic [31:0] hrdata,
  output logic        hsel = 0, hwrite = 0,
  output logic [1:0]  htrans = 0,
  output logic [31:0] haddr = 0, hwdata = 0
);
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] q);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    q = hrdata;
    // Released data must not look still valid
    hwdata <= ~d;
  endtask
endmodule

//--- dv/rtc_status_flags_tb.sv
// Bench for the status flag block against a reference model
`timescale 1ns/1ps
bind rsf_top rsf_assertions u_rsf_assertions (.*);
module rtc_status_flags_tb;
  import rsf_pkg::*;
  logic hclk = 0, hresetn = 0, clk_en = 1, hsel, hwrite, hreadyout, hresp;
  logic supply_low = 0, alarm_irq_n_in = 1, int_out, v;
  logic [1:0] htrans;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr, hwdata, hrdata, cur_time, q, t, a, r, im, s = 1682;
  int mismatches = 0, check_count = 0, n;
  rsf_top u_rsf_top (.hready(hreadyout), .*);
  rsf_host u_rsf_host (.hready(hreadyout), .*);
  always #20 hclk = ~hclk;
  initial #3_000_000 begin mismatches++; conclude(); end
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic hit(logic [31:0] tm, al, logic [3:0] m);
    hit = 1'b1;
    for (int i = 0; i < FIELDS; i++)
      if (!m[i] && tm[8*i+:8] !== al[8*i+:8]) hit = 1'b0;
  endfunction
  task automatic check(logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rd(logic [7:0] ad, logic [31:0] e);
    u_rsf_host.xfer(1'b0, ad, 32'h0, q);
    check(q, e);
    check(32'({hreadyout, hresp}), 32'h2);
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    u_rsf_host.xfer(1'b1, ad, d, q);
  endtask
  initial begin
    cur_time = xs();
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_STATUS, 32'(STATUS_RST));
    supply_low <= 1'b1;
    @(posedge hclk);
    supply_low <= 1'b0;
    rd(OFF_STATUS, 32'h20);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_STATUS, 32'h20);
    rd(OFF_STATUS, 32'h0);
    // Frozen clock enable must not let a supply dip reach the flag
    clk_en <= 1'b0;
    supply_low <= 1'b1;
    repeat (3) @(posedge hclk);
    clk_en <= 1'b1;
    supply_low <= 1'b0;
    @(posedge hclk);
    rd(OFF_STATUS, 32'h0);
    for (int m = 0; m < 16; m++)
      for (int k = 0; k < 2; k++) begin
        a = xs();
        r = xs() | 32'h01010101;
        im = 0;
        for (int i = 0; i < FIELDS; i++) if (m[i]) im[8*i+:8] = 8'hff;
        t = k ? a ^ r : a ^ (r & im);
        cur_time <= ~a;
        wr(OFF_ALARM, a);
        wr(OFF_ENABLE, 32'(m));
        repeat (2) @(posedge hclk);
        u_rsf_host.xfer(1'b0, OFF_STATUS, 32'h0, q);
        cur_time <= t;
        repeat (2) @(posedge hclk);
        rd(OFF_STATUS, {25'h0, hit(t, a, 4'(m)) && m != 15, 6'h0});
      end
    t = xs();
    cur_time <= t;
    wr(OFF_STATUS, 32'h1);
    cur_time <= ~t;
    repeat (2) rd(OFF_HOLD, t);
    wr(OFF_STATUS, 32'h0);
    @(posedge hclk);
    rd(OFF_HOLD, ~t);
    wr(OFF_STATUS, 32'h4);
    for (int j = 0; j < 2; j++) begin
      v = int_out;
      n = 0;
      while (int_out === v && n < 30000) begin
        @(posedge hclk);
        n++;
      end
    end
    check(32'(n), CAL_HALF);
    wr(OFF_STATUS, 32'h0);
    repeat (8) begin
      alarm_irq_n_in <= ^xs();
      repeat (2) @(posedge hclk);
      check(32'(int_out), 32'(alarm_irq_n_in));
    end
    conclude();
  end
endmodule
